/* reset_seq_pkg.sv */
package reset_seq_pkg;

  // Clock rates
  localparam int OSCILLATOR_CLOCK_HZ = 200_000_000;

  // Stretch counts in cycles
  localparam int POR_STRETCH_CYCLES = 64;
  localparam int COMBINED_SYNC_CYCLES = 3;
  localparam int CLKGEN_STRETCH_CYCLES = 32;
  localparam int PERIP_STRETCH_CYCLES = 32;
  localparam int CORE_STRETCH_CYCLES = 32;

  // Counter width covers the largest stretch
  localparam int CNT_W = 7;
  typedef logic [CNT_W-1:0] cnt_t;

  // Reset value of every counter
  localparam cnt_t CNT_RESET = 7'h00;

  // Stage of the staged release
  typedef enum logic [2:0] {
    ST_COMBINED,
    ST_CLKGEN,
    ST_PERIP,
    ST_CORE,
    ST_RUN
  } stage_e;

  // Raw reset sources, all active high
  typedef struct packed {
    logic powerOn;
    logic extPin;
    logic softwareReq;
    logic watchdogTimeout;
    logic clockLoss;
  } reset_src_s;

  // Downstream resets, all active high
  typedef struct packed {
    logic clockGeneratorReset;
    logic peripheralReset;
    logic coreReset;
    logic syncLogicReset;
    logic debugPortReset;
  } reset_out_s;

  // Every downstream reset asserted while srst is high
  localparam reset_out_s RESETS_AFTER_SRST = 5'h1f;

endpackage

/* stretch_counter.sv */
module stretch_counter
  import reset_seq_pkg::*;
#(
  parameter cnt_t LIMIT = 7'h20
)
(
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic enable,
  output logic done
);

  // Count of enabled cycles since clear
  cnt_t count_reg;
  cnt_t count_next;

  // Saturate at the limit
  always_comb
  begin
    count_next = count_reg;
    if (clear)
    begin
      count_next = CNT_RESET;
    end
    else if (enable && (count_reg != LIMIT))
    begin
      count_next = count_reg + 7'h01;
    end
  end

  // Register only
  always_ff @(posedge ref_clk)
  begin
    count_reg <= count_next;
  end

  // Done once limit is reached
  assign done = (count_reg == LIMIT);

endmodule

/* staged_reset_release_sequencer.sv */
// Function
// [R1] Five sources: pin, power-on, software, watchdog, clock-loss
// [R2] Power-on stretched 64 oscillator cycles
// [R3] Combined reset ORs all; holds everything else
// [R4] Control, sync generator, clkgen stretcher wait combined
// [R5] Software/watchdog logic released three cycles after
// [R6] Clock-generator reset released 32 cycles after combined
// [R7] Clkgen release enables clocks, starts peripheral stretch
// [R8] Peripheral reset released 32 system cycles later
// [R9] Peripheral release starts core stretcher
// [R10] Core reset released 32 cycles after peripheral
// [R11] Core release marks start-up complete
// [R12] Early counters use oscillator clock
// [R13] Total combined-to-clkgen stretch up to 96 cycles
// [R14] Clkgen reset released on a clock edge
// [R15] Peripheral, core resets released on clock edges
// [R16] Debug port reset only by power-on
// [R17] No interrupts raised
// [R18] Any source reassertion restarts whole sequence; code ignores soft, watchdog, clock-loss while sync logic held
module staged_reset_release_sequencer
  import reset_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic powerOnRaw,
  input wire logic extResetPin_n,
  input wire logic softwareReset,
  input wire logic watchdogTimeoutReset,
  input wire logic clockLossReset,
  output logic clockGeneratorReset,
  output logic peripheralReset,
  output logic coreReset,
  output logic syncLogicReset,
  output logic debugPortReset,
  output logic startupDone
);

  // Synchroniser stages for the two pin sources
  logic porMeta_reg;
  logic porSync_reg;
  logic extMeta_reg;
  logic extSync_reg;

  // Two flops before any logic reads a pin
  always_ff @(posedge ref_clk)
  begin
    porMeta_reg <= powerOnRaw;
    porSync_reg <= porMeta_reg;
    extMeta_reg <= ~extResetPin_n;
    extSync_reg <= extMeta_reg;
  end

  // Source bundle
  reset_src_s src;
  always_comb
  begin
    src.powerOn = porSync_reg | srst; // [R1]
    src.extPin = extSync_reg; // [R1]
    src.softwareReq = softwareReset; // [R1]
    src.watchdogTimeout = watchdogTimeoutReset; // [R1]
    src.clockLoss = clockLossReset; // [R1]
  end

  // Power-on stretcher, free of combined reset
  logic porDone;
  stretch_counter #(
    .LIMIT(cnt_t'(POR_STRETCH_CYCLES))
  ) u_por_stretch (
    .ref_clk(ref_clk),
    .clear(src.powerOn),
    .enable(1'b1),
    .done(porDone)
  );
  // Stretched power-on, counted on oscillator clock
  logic extendedPor;
  assign extendedPor = ~porDone; // [R2] [R12]

  // Sync-source gating: soft/watchdog/clock-loss inputs ignored while sync logic is held
  logic syncHeld;
  logic combined;
  // OR of all sources; soft, watchdog, clock-loss reassertion ignored while syncHeld
  assign combined = extendedPor | src.extPin
    | ((src.softwareReq | src.watchdogTimeout | src.clockLoss) & ~syncHeld); // [R3] [R18]

  // Sync reset generator counter
  logic syncDone;
  stretch_counter #(
    .LIMIT(cnt_t'(COMBINED_SYNC_CYCLES))
  ) u_sync_stretch (
    .ref_clk(ref_clk),
    .clear(combined),
    .enable(1'b1),
    .done(syncDone)
  );
  assign syncHeld = ~syncDone; // [R5] [R4]

  // Clock-generator stretcher
  logic clkgenDone;
  stretch_counter #(
    .LIMIT(cnt_t'(CLKGEN_STRETCH_CYCLES))
  ) u_clkgen_stretch (
    .ref_clk(ref_clk),
    .clear(combined),
    .enable(1'b1),
    .done(clkgenDone)
  );

  // Stage state
  stage_e stage_reg;
  stage_e stage_next;

  // Peripheral and core stretchers
  logic peripDone;
  logic coreDone;
  stretch_counter #(
    .LIMIT(cnt_t'(PERIP_STRETCH_CYCLES))
  ) u_perip_stretch (
    .ref_clk(ref_clk),
    .clear(stage_reg != ST_PERIP),
    .enable(1'b1),
    .done(peripDone)
  );
  stretch_counter #(
    .LIMIT(cnt_t'(CORE_STRETCH_CYCLES))
  ) u_core_stretch (
    .ref_clk(ref_clk),
    .clear(stage_reg != ST_CORE),
    .enable(1'b1),
    .done(coreDone)
  );

  // Next stage
  always_comb
  begin
    stage_next = stage_reg;
    if (combined)
    begin
      stage_next = ST_COMBINED; // [R18]
    end
    else
    begin
      unique case (stage_reg)
        // Waiting for combined release
        ST_COMBINED:
        begin
          stage_next = ST_CLKGEN; // [R4]
        end
        // Clock-generator stretch
        ST_CLKGEN:
        begin
          if (clkgenDone)
          begin
            stage_next = ST_PERIP; // [R6] [R13]
          end
        end
        // Peripheral stretch
        ST_PERIP:
        begin
          if (peripDone)
          begin
            stage_next = ST_CORE; // [R8] [R9]
          end
        end
        // Core stretch
        ST_CORE:
        begin
          if (coreDone)
          begin
            stage_next = ST_RUN; // [R10]
          end
        end
        // Running
        ST_RUN:
        begin
          stage_next = ST_RUN;
        end
      endcase
    end
  end

  // Registered outputs, next values
  reset_out_s out_reg;
  reset_out_s out_next;
  logic done_reg;
  logic done_next;

  // Output decode from next stage, combined/syncHeld and extendedPor, released on the clock edge
  always_comb
  begin
    out_next.clockGeneratorReset = (stage_next == ST_COMBINED) || (stage_next == ST_CLKGEN); // [R14] [R7]
    out_next.peripheralReset = out_next.clockGeneratorReset || (stage_next == ST_PERIP); // [R15] [R8]
    out_next.coreReset = out_next.peripheralReset || (stage_next == ST_CORE); // [R15] [R10]
    out_next.syncLogicReset = combined | syncHeld; // [R5]
    out_next.debugPortReset = extendedPor; // [R16]
    done_next = (stage_next == ST_RUN); // [R11]
  end

  // Registers; srst is a power-on source and also a synchronous reset of these flops
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stage_reg <= ST_COMBINED;
      out_reg <= RESETS_AFTER_SRST;
      done_reg <= 1'b0;
    end
    else
    begin
      stage_reg <= stage_next;
      out_reg <= out_next;
      done_reg <= done_next;
    end
  end

  // Output drive; no interrupt output exists
  assign clockGeneratorReset = out_reg.clockGeneratorReset;
  assign peripheralReset = out_reg.peripheralReset;
  assign coreReset = out_reg.coreReset;
  assign syncLogicReset = out_reg.syncLogicReset;
  assign debugPortReset = out_reg.debugPortReset;
  assign startupDone = done_reg; // [R17]

  // Saturating age step, cleared while the watched reset is high
  function automatic logic [7:0] ageStep(input logic [7:0] age, input logic hold);
    if (hold)
    begin
      return 8'h00;
    end
    return (age == 8'hff) ? age : age + 8'h01;
  endfunction

  // Helper ages: cycles since combined, clkgen and peripheral resets were high
  logic [7:0] combAge_reg;
  logic [7:0] combAge_next;
  logic [7:0] clkgenAge_reg;
  logic [7:0] clkgenAge_next;
  logic [7:0] peripAge_reg;
  logic [7:0] peripAge_next;

  // Next ages; a combined reset restarts all three
  always_comb
  begin
    combAge_next = ageStep(combAge_reg, srst || combined);
    clkgenAge_next = ageStep(clkgenAge_reg, srst || combined || clockGeneratorReset);
    peripAge_next = ageStep(peripAge_reg, srst || combined || peripheralReset);
  end

  // Register only
  always_ff @(posedge ref_clk)
  begin
    combAge_reg <= combAge_next;
    clkgenAge_reg <= clkgenAge_next;
    peripAge_reg <= peripAge_next;
  end

  // Combined reset forces clock generator into reset next cycle
  property p_combined_holds;
    @(posedge ref_clk) disable iff (srst)
      combined |=> clockGeneratorReset;
  endproperty
  a_combined_holds: assert property (p_combined_holds) else $error("clkgen not held by combined"); // [R3]

  // Clock-generator reset held the full stretch after combined drops
  property p_clkgen_min;
    @(posedge ref_clk) disable iff (srst)
      !clockGeneratorReset |-> (combAge_reg >= CLKGEN_STRETCH_CYCLES);
  endproperty
  a_clkgen_min: assert property (p_clkgen_min) else $error("clkgen released early"); // [R6]

  // Clock generator released within bound after combined drop
  property p_clkgen_max;
    @(posedge ref_clk) disable iff (srst)
      (combAge_reg >= CLKGEN_STRETCH_CYCLES + 2) |-> !clockGeneratorReset;
  endproperty
  a_clkgen_max: assert property (p_clkgen_max) else $error("clkgen not released"); // [R6] [R13]

  // Peripheral released no later than just after its stretch
  property p_perip_timing;
    @(posedge ref_clk) disable iff (srst)
      (clkgenAge_reg >= PERIP_STRETCH_CYCLES + 2) |-> !peripheralReset;
  endproperty
  a_perip_timing: assert property (p_perip_timing) else $error("peripheral release late"); // [R8]

  // Peripheral held the full stretch after clkgen release
  property p_perip_min;
    @(posedge ref_clk) disable iff (srst)
      !peripheralReset |-> (clkgenAge_reg >= PERIP_STRETCH_CYCLES);
  endproperty
  a_perip_min: assert property (p_perip_min) else $error("peripheral released early"); // [R8]

  // Peripheral never released before clkgen
  property p_order;
    @(posedge ref_clk) disable iff (srst)
      clockGeneratorReset |-> peripheralReset && coreReset;
  endproperty
  a_order: assert property (p_order) else $error("release order violated"); // [R7] [R9]

  // Core released no sooner than 31 cycles after peripheral
  property p_core_timing;
    @(posedge ref_clk) disable iff (srst)
      $fell(coreReset) |-> peripAge_reg >= 8'h1f;
  endproperty
  a_core_timing: assert property (p_core_timing) else $error("core released early"); // [R10]

  // Core released within bound after peripheral release
  property p_core_max;
    @(posedge ref_clk) disable iff (srst)
      (peripAge_reg >= CORE_STRETCH_CYCLES + 2) |-> !coreReset;
  endproperty
  a_core_max: assert property (p_core_max) else $error("core release late"); // [R10]

  // Startup done matches core release
  property p_done;
    @(posedge ref_clk) disable iff (srst)
      startupDone == !coreReset;
  endproperty
  a_done: assert property (p_done) else $error("startup flag mismatch"); // [R11]

  // Sync logic held while combined asserted
  property p_sync_hold;
    @(posedge ref_clk) disable iff (srst)
      combined |=> syncLogicReset [*3];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync logic released early"); // [R5]

  // Debug port follows power-on only
  property p_debug;
    @(posedge ref_clk) disable iff (srst)
      (!extendedPor && src.extPin) |=> !debugPortReset;
  endproperty
  a_debug: assert property (p_debug) else $error("debug reset by non power-on"); // [R16]

endmodule

/* reset_consumer_model.sv */
module reset_consumer_model
  import reset_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clockGeneratorReset,
  input wire logic peripheralReset,
  input wire logic coreReset,
  output logic orderFault,
  output logic coreRunning
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sticky flag for a release out of order
  initial orderFault = 1'b0;
  // Core idle until its reset drops
  initial coreRunning = 1'b0;
  // Each consumer checks that the stage ahead of it runs first
  always @(posedge ref_clk)
  begin
    // Peripherals need running clocks
    if (!peripheralReset && clockGeneratorReset)
    begin
      orderFault <= 1'b1;
    end
    // Core needs running peripherals
    if (!coreReset && peripheralReset)
    begin
      orderFault <= 1'b1;
    end
    // Core fetches once out of reset
    coreRunning <= !coreReset;
  end
endmodule

/* tb_staged_reset_release_sequencer.sv */
module tb_staged_reset_release_sequencer
  import reset_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs
  logic ref_clk, srst, powerOnRaw, extResetPin_n;
  logic softwareReset, watchdogTimeoutReset, clockLossReset;
  // Design outputs
  logic clockGeneratorReset, peripheralReset, coreReset;
  logic syncLogicReset, debugPortReset, startupDone;
  // Partner flags
  logic orderFault, coreRunning;
  // Bookkeeping
  int numErrors = 0;
  int checkCount = 0;
  int seed = 32'hb89d;
  int n;
  int m;
  int unsigned d;

  staged_reset_release_sequencer i_staged_reset_release_sequencer (
    .ref_clk(ref_clk), .srst(srst), .powerOnRaw(powerOnRaw), .extResetPin_n(extResetPin_n),
    .softwareReset(softwareReset), .watchdogTimeoutReset(watchdogTimeoutReset),
    .clockLossReset(clockLossReset), .clockGeneratorReset(clockGeneratorReset),
    .peripheralReset(peripheralReset), .coreReset(coreReset), .syncLogicReset(syncLogicReset),
    .debugPortReset(debugPortReset), .startupDone(startupDone));

  reset_consumer_model i_reset_consumer_model (
    .ref_clk(ref_clk), .clockGeneratorReset(clockGeneratorReset),
    .peripheralReset(peripheralReset), .coreReset(coreReset),
    .orderFault(orderFault), .coreRunning(coreRunning));

  // Free running clock, 5 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pick one reset output
  function automatic logic pick(input int s);
    case (s)
      0: return clockGeneratorReset;
      1: return peripheralReset;
      2: return coreReset;
      3: return syncLogicReset;
      default: return debugPortReset;
    endcase
  endfunction

  // Nominal stretch of each output
  function automatic int nominal(input int s);
    case (s)
      0: return CLKGEN_STRETCH_CYCLES;
      1: return PERIP_STRETCH_CYCLES;
      2: return CORE_STRETCH_CYCLES;
      3: return COMBINED_SYNC_CYCLES;
      default: return POR_STRETCH_CYCLES;
    endcase
  endfunction

  // Counts, verdict, end of run
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compare one level
  task automatic check_bit(input logic got, input logic exp);
    checkCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Compare a delay, allowing sync and register latency
  task automatic check_range(input int got, input int lo);
    checkCount++;
    if (got < lo || got > lo + 6)
    begin
      numErrors++;
      $display("Error t=%0t got %h exp %h..%h", $time, got, lo, lo + 6);
    end
  endtask

  // Bounded wait for an output to drop
  task automatic wait_low(input int s, output int cnt);
    cnt = 0;
    while (pick(s) !== 1'b0)
    begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > 200)
      begin
        numErrors++;
        $display("Error t=%0t got %h exp %h", $time, cnt, 200);
        report_and_stop();
      end
    end
  endtask

  // Set one reset source active or idle
  task automatic drive(input int which, input logic v);
    case (which)
      0: extResetPin_n = !v;
      1: softwareReset = v;
      2: watchdogTimeoutReset = v;
      default: clockLossReset = v;
    endcase
  endtask

  // Staged release from the moment combined reset drops
  task automatic staged();
    wait_low(3, n);
    check_range(n, nominal(3));
    wait_low(0, m);
    check_range(n + m, nominal(0));
    check_bit(peripheralReset, 1'b1);
    wait_low(1, n);
    check_range(n, nominal(1));
    check_bit(coreReset, 1'b1);
    wait_low(2, n);
    check_range(n, nominal(2));
    @(negedge ref_clk);
    check_bit(startupDone, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1;
    powerOnRaw = 1'b1;
    extResetPin_n = 1'b1;
    softwareReset = 1'b0;
    watchdogTimeoutReset = 1'b0;
    clockLossReset = 1'b0;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check_bit(clockGeneratorReset, 1'b1);
    check_bit(debugPortReset, 1'b1);
    powerOnRaw = 1'b0;
    wait_low(4, n);
    check_range(n, nominal(4));
    staged();
    // Each source except power-on aborts a release at a random point, then restarts it
    for (int i = 0; i < 4; i++)
    begin
      drive(0, 1'b1);
      repeat (5) @(negedge ref_clk);
      drive(0, 1'b0);
      d = $random(seed);
      repeat (10 + d % 100) @(negedge ref_clk);
      // Pin passes two sync flops; a synchronous request is a one-cycle pulse
      drive(i, 1'b1);
      repeat ((i == 0) ? 5 + d % 3 : 1) @(negedge ref_clk);
      check_bit(clockGeneratorReset, 1'b1);
      check_bit(peripheralReset, 1'b1);
      check_bit(coreReset, 1'b1);
      check_bit(startupDone, 1'b0);
      check_bit(debugPortReset, 1'b0);
      drive(i, 1'b0);
      staged();
    end
    check_bit(orderFault, 1'b0);
    check_bit(coreRunning, 1'b1);
    report_and_stop();
  end
endmodule
